// >>> rss_pkg.sv
// package: opcodes, states, register map, status layout and timing constants
package rss_pkg;

    // operations handled by this execution block
    typedef enum logic [2:0] {
        RSS_OP_NONE = 3'h0,
        RSS_OP_RETURN_WITH_LITERAL = 3'h1,
        RSS_OP_ROTATE_RIGHT_VIA_CARRY = 3'h2,
        RSS_OP_SUBTRACT_W_FROM_FILE = 3'h3,
        RSS_OP_SUBTRACT_W_FROM_IMMEDIATE = 3'h4,
        RSS_OP_SLEEP = 3'h5
    } rss_op_e;

    // execution sequencer, one-hot
    typedef enum logic [3:0] {
        RSS_ST_IDLE = 4'h1,
        RSS_ST_FILE = 4'h2,
        RSS_ST_RET2 = 4'h4,
        RSS_ST_SLEEP = 4'h8
    } rss_state_e;

    // register port offsets
    localparam logic [7:0] RSS_REG_W = 8'h00;
    localparam logic [7:0] RSS_REG_STATUS = 8'h01;
    localparam logic [7:0] RSS_REG_PC = 8'h02;
    localparam logic [7:0] RSS_REG_WDOG = 8'h03;
    localparam logic [7:0] RSS_REG_CTRL = 8'h04;

    // status register fields
    localparam int RSS_ST_C = 0;
    localparam int RSS_ST_DC = 1;
    localparam int RSS_ST_Z = 2;
    localparam int RSS_ST_PD = 3;
    localparam int RSS_ST_TO = 4;
    localparam int RSS_STATUS_BITS = 5;

    // control register fields
    localparam int RSS_CTRL_WDOG_EN = 0;

    // reset values
    localparam logic [7:0] RSS_W_RST = 8'h00;
    localparam logic [4:0] RSS_STATUS_RST = 5'h18;
    localparam logic [12:0] RSS_PC_RST = 13'h0000;
    localparam logic [7:0] RSS_WDOG_CLEAR = 8'h00;
    localparam logic [0:0] RSS_CTRL_RST = 1'h0;

    // widths
    localparam int RSS_FILE_AW = 7;
    localparam int RSS_FILE_DEPTH = 128;
    localparam int RSS_PC_W = 13;

    // watchdog time base: core clock and tick period
    localparam int RSS_CLK_HZ = 40000000;
    localparam int RSS_WDOG_TICK_US = 1;
    localparam int RSS_WDOG_TICK_CYC = RSS_CLK_HZ / 1000000 * RSS_WDOG_TICK_US;
    localparam logic [7:0] RSS_PRESCALE_LAST = 8'hFF;

endpackage : rss_pkg

// >>> rss_mem_if.sv
// interface: file register memory port between core and memory
`timescale 1ns/100ps
`default_nettype none
interface rss_mem_if;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic we;
    logic [7:0] rdata;

    modport core (output addr, output wdata, output we, input rdata);
    modport mem (input addr, input wdata, input we, output rdata);
endinterface : rss_mem_if
`default_nettype wire

// >>> rss_file_mem.sv
// module: 128-byte file register memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module rss_file_mem (
    input wire logic clk_in,     // core clock
    input wire logic rst_in,     // sync reset, high
    rss_mem_if.mem port          // core access
);
    logic [7:0] store [rss_pkg::RSS_FILE_DEPTH];
    logic [7:0] next_rdata;
    logic [7:0] rdata_q;

    // read returns the old byte when written in the same cycle
    always_comb begin
        next_rdata = store[port.addr];
    end

    // array itself has no reset, only the read register
    always_ff @(posedge clk_in) begin
        if (port.we) begin
            store[port.addr] <= port.wdata;
        end
        if (rst_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= next_rdata;
        end
    end

    assign port.rdata = rdata_q;
endmodule : rss_file_mem
`default_nettype wire

// >>> rss_watchdog.sv
// module: watchdog counter with its prescaler and clear input
`timescale 1ns/100ps
`default_nettype none
module rss_watchdog (
    input wire logic clk_in,        // core clock
    input wire logic rst_in,        // sync reset, high
    input wire logic enable_in,     // count enable
    input wire logic tick_in,       // time base pulse
    input wire logic clear_in,      // clear counter and prescaler
    output logic [7:0] count_out,   // counter value
    output logic timeout_out        // overflow pulse
);
    logic [7:0] prescale;
    logic [7:0] count;
    logic [7:0] next_prescale;
    logic [7:0] next_count;
    logic next_timeout;
    logic timeout;

    // clear outranks counting so a sleep never sees a stale overflow
    always_comb begin
        next_prescale = prescale;
        next_count = count;
        next_timeout = 1'b0;
        if (clear_in) begin
            next_prescale = 8'h00;
            next_count = rss_pkg::RSS_WDOG_CLEAR;
        end else if (enable_in && tick_in) begin
            next_prescale = prescale + 8'h01;
            if (prescale == rss_pkg::RSS_PRESCALE_LAST) begin
                next_count = count + 8'h01;
                next_timeout = (count == 8'hFF);
            end
        end
    end

    // state registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prescale <= 8'h00;
            count <= rss_pkg::RSS_WDOG_CLEAR;
            timeout <= 1'b0;
        end else begin
            prescale <= next_prescale;
            count <= next_count;
            timeout <= next_timeout;
        end
    end

    assign count_out = count;
    assign timeout_out = timeout;
endmodule : rss_watchdog
`default_nettype wire

// >>> rss_core.sv
// module: executes return-with-literal, rotate, both subtracts and sleep
//
// Summary of operation
// - return-with-literal loads W, pops PC from stack
// - return-with-literal is one word, two cycles
// - rotate right through carry, destination bit picks
// - file minus W, steered by destination bit
// - carry and digit carry set when W fits
// - literal minus W always written to W
// - sleep clears powerdown flag, sets timeout flag
// - sleep clears watchdog counter and its prescaler
// - after sleep stay halted, oscillator stopped, until a wake level or a watchdog overflow
`timescale 1ns/100ps
`default_nettype none
module rss_core (
    input wire logic core_clk_in,            // 40 MHz core clock
    input wire logic rst_in,                 // sync reset, high
    input wire logic [7:0] bus_addr_in,      // register address
    input wire logic [7:0] bus_wdata_in,     // register write data
    input wire logic bus_wr_in,              // write strobe
    input wire logic bus_rd_in,              // read strobe
    output logic [15:0] bus_rdata_out,       // read data, cycle after strobe
    input wire logic instr_valid_in,         // instruction offered
    input wire logic [2:0] instr_op_in,      // operation code
    input wire logic [6:0] instr_file_in,    // file address
    input wire logic instr_dest_in,          // 0 to W, 1 to file
    input wire logic [7:0] instr_imm_in,     // immediate operand
    output logic instr_ready_out,            // accepts an instruction
    output logic instr_done_out,             // instruction completes
    input wire logic [12:0] stack_top_in,    // return address on stack top
    output logic stack_pop_out,              // pop pulse
    output logic [12:0] pc_out,              // program counter
    output logic [7:0] w_out,                // working register
    output logic [4:0] status_out,           // carry, dc, zero, pd, to
    output logic halted_out,                 // core halted in sleep
    output logic osc_run_out,                // main oscillator enable
    input wire logic wake_pin_in             // async wake request
);
    rss_mem_if mem_if ();

    rss_pkg::rss_state_e state;
    rss_pkg::rss_state_e next_state;
    rss_pkg::rss_op_e op_in;
    rss_pkg::rss_op_e lat_op;
    rss_pkg::rss_op_e next_lat_op;
    logic [6:0] lat_file;
    logic [6:0] next_lat_file;
    logic lat_dest;
    logic next_lat_dest;
    logic [7:0] w;
    logic [7:0] next_w;
    logic [4:0] status;
    logic [4:0] next_status;
    logic [12:0] pc;
    logic [12:0] next_pc;
    logic [0:0] ctrl;
    logic [0:0] next_ctrl;
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic [7:0] div_cnt;
    logic [7:0] next_div_cnt;
    logic wdog_tick;
    logic wdog_clear;
    logic wdog_timeout;
    logic [7:0] wdog_count;
    logic [2:0] wake_sync;
    logic wake_level;
    logic next_wake_level;
    logic issue;
    logic [10:0] sub_res;
    logic [7:0] rot_res;

    // result byte plus carry, dc and zero of a minus b
    function automatic logic [10:0] sub_flags(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] diff;
        diff = a - b;
        sub_flags = {diff, (diff == 8'h00), (b[3:0] <= a[3:0]), (b <= a)};
    endfunction : sub_flags

    assign op_in = rss_pkg::rss_op_e'(instr_op_in);
    assign issue = instr_valid_in && (state == rss_pkg::RSS_ST_IDLE);

    rss_file_mem u_mem (
        .clk_in(core_clk_in),
        .rst_in(rst_in),
        .port(mem_if.mem)
    );

    rss_watchdog u_wdog (
        .clk_in(core_clk_in),
        .rst_in(rst_in),
        .enable_in(ctrl[rss_pkg::RSS_CTRL_WDOG_EN]),
        .tick_in(wdog_tick),
        .clear_in(wdog_clear),
        .count_out(wdog_count),
        .timeout_out(wdog_timeout)
    );

    // time base divider for the watchdog prescaler
    always_comb begin
        if (div_cnt == 8'(rss_pkg::RSS_WDOG_TICK_CYC - 1)) begin
            next_div_cnt = 8'h00;
        end else begin
            next_div_cnt = div_cnt + 8'h01;
        end
        wdog_tick = (div_cnt == 8'(rss_pkg::RSS_WDOG_TICK_CYC - 1));
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    // wake pin filter: accept a level once stages two and three agree
    always_comb begin
        next_wake_level = wake_level;
        if (wake_sync[1] == wake_sync[2]) begin
            next_wake_level = wake_sync[2];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wake_sync <= 3'h0;
            wake_level <= 1'b0;
        end else begin
            wake_sync <= {wake_sync[1:0], wake_pin_in};
            wake_level <= next_wake_level;
        end
    end

    // operand data: file byte arrives registered in the second cycle
    always_comb begin
        if (lat_op == rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_CARRY) begin
            rot_res = {status[rss_pkg::RSS_ST_C], mem_if.rdata[7:1]};
        end else begin
            rot_res = 8'h00;
        end
        sub_res = sub_flags(mem_if.rdata, w);
    end

    // memory port: address the operand at issue, write back in the file cycle
    always_comb begin
        mem_if.addr = (state == rss_pkg::RSS_ST_FILE) ? lat_file : instr_file_in;
        mem_if.we = 1'b0;
        mem_if.wdata = 8'h00;
        if (state == rss_pkg::RSS_ST_FILE && lat_dest) begin
            mem_if.we = 1'b1;
            if (lat_op == rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_CARRY) begin
                mem_if.wdata = rot_res;
            end else begin
                mem_if.wdata = sub_res[10:3];
            end
        end
    end

    // sequencer and architectural state, next values
    always_comb begin
        logic [10:0] sf;
        sf = 11'h000;
        next_state = state;
        next_lat_op = lat_op;
        next_lat_file = lat_file;
        next_lat_dest = lat_dest;
        next_w = w;
        next_status = status;
        next_pc = pc;
        next_ctrl = ctrl;
        stack_pop_out = 1'b0;
        instr_done_out = 1'b0;
        wdog_clear = 1'b0;
        // software writes first, so an instruction in the same cycle wins
        if (bus_wr_in) begin
            case (bus_addr_in)
                rss_pkg::RSS_REG_W: next_w = bus_wdata_in;
                rss_pkg::RSS_REG_STATUS: next_status = bus_wdata_in[4:0];
                rss_pkg::RSS_REG_CTRL: next_ctrl = bus_wdata_in[0:0];
                default: next_ctrl = next_ctrl;
            endcase
        end
        case (state)
            rss_pkg::RSS_ST_IDLE: begin
                if (issue) begin
                    next_lat_op = op_in;
                    next_lat_file = instr_file_in;
                    next_lat_dest = instr_dest_in;
                    case (op_in)
                        rss_pkg::RSS_OP_RETURN_WITH_LITERAL: begin
                            next_w = instr_imm_in;
                            next_pc = stack_top_in;
                            stack_pop_out = 1'b1;
                            next_state = rss_pkg::RSS_ST_RET2;
                        end
                        rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_CARRY,
                        rss_pkg::RSS_OP_SUBTRACT_W_FROM_FILE: begin
                            next_state = rss_pkg::RSS_ST_FILE;
                        end
                        rss_pkg::RSS_OP_SUBTRACT_W_FROM_IMMEDIATE: begin
                            sf = sub_flags(instr_imm_in, w);
                            next_w = sf[10:3];
                            next_status[rss_pkg::RSS_ST_C] = sf[0];
                            next_status[rss_pkg::RSS_ST_DC] = sf[1];
                            next_status[rss_pkg::RSS_ST_Z] = sf[2];
                            instr_done_out = 1'b1;
                        end
                        rss_pkg::RSS_OP_SLEEP: begin
                            next_status[rss_pkg::RSS_ST_PD] = 1'b0;
                            next_status[rss_pkg::RSS_ST_TO] = 1'b1;
                            wdog_clear = 1'b1;
                            instr_done_out = 1'b1;
                            next_state = rss_pkg::RSS_ST_SLEEP;
                        end
                        default: begin
                            instr_done_out = 1'b1;
                        end
                    endcase
                end
            end
            rss_pkg::RSS_ST_FILE: begin
                if (lat_op == rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_CARRY) begin
                    next_status[rss_pkg::RSS_ST_C] = mem_if.rdata[0];
                    if (!lat_dest) begin
                        next_w = rot_res;
                    end
                end else begin
                    sf = sub_res;
                    if (!lat_dest) begin
                        next_w = sf[10:3];
                    end
                    next_status[rss_pkg::RSS_ST_C] = sf[0];
                    next_status[rss_pkg::RSS_ST_DC] = sf[1];
                    next_status[rss_pkg::RSS_ST_Z] = sf[2];
                end
                instr_done_out = 1'b1;
                next_state = rss_pkg::RSS_ST_IDLE;
            end
            rss_pkg::RSS_ST_RET2: begin
                // second cycle raises done and returns to idle; no instruction is taken
                instr_done_out = 1'b1;
                next_state = rss_pkg::RSS_ST_IDLE;
            end
            rss_pkg::RSS_ST_SLEEP: begin
                // only a wake level or a watchdog overflow ends the halt
                if (wake_level || wdog_timeout) begin
                    next_state = rss_pkg::RSS_ST_IDLE;
                end
            end
            default: begin
                next_state = rss_pkg::RSS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state <= rss_pkg::RSS_ST_IDLE;
            lat_op <= rss_pkg::RSS_OP_NONE;
            lat_file <= 7'h00;
            lat_dest <= 1'b0;
            w <= rss_pkg::RSS_W_RST;
            status <= rss_pkg::RSS_STATUS_RST;
            pc <= rss_pkg::RSS_PC_RST;
            ctrl <= rss_pkg::RSS_CTRL_RST;
        end else begin
            state <= next_state;
            lat_op <= next_lat_op;
            lat_file <= next_lat_file;
            lat_dest <= next_lat_dest;
            w <= next_w;
            status <= next_status;
            pc <= next_pc;
            ctrl <= next_ctrl;
        end
    end

    // register read mux, answered one cycle after the strobe
    always_comb begin
        next_rdata = 16'h0000;
        if (bus_rd_in) begin
            case (bus_addr_in)
                rss_pkg::RSS_REG_W: next_rdata = {8'h00, w};
                rss_pkg::RSS_REG_STATUS: next_rdata = {11'h000, status};
                rss_pkg::RSS_REG_PC: next_rdata = {3'h0, pc};
                rss_pkg::RSS_REG_WDOG: next_rdata = {8'h00, wdog_count};
                rss_pkg::RSS_REG_CTRL: next_rdata = {15'h0000, ctrl};
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign bus_rdata_out = rdata;
    assign instr_ready_out = (state == rss_pkg::RSS_ST_IDLE);
    assign pc_out = pc;
    assign w_out = w;
    assign status_out = status;
    assign halted_out = (state == rss_pkg::RSS_ST_SLEEP);
    assign osc_run_out = (state != rss_pkg::RSS_ST_SLEEP); // oscillator gated in sleep
endmodule : rss_core
`default_nettype wire

// >>> rss_core_asserts.sv
// checker: concurrent properties on the ports of rss_core
`timescale 1ns/100ps
`default_nettype none
module rss_core_asserts (
    input wire logic core_clk_in,         // core clock
    input wire logic rst_in,              // sync reset, high
    input wire logic instr_valid_in,      // instruction offered
    input wire logic [2:0] instr_op_in,   // operation code
    input wire logic instr_dest_in,       // destination select
    input wire logic [7:0] instr_imm_in,  // immediate operand
    input wire logic instr_ready_out,     // core idle
    input wire logic instr_done_out,      // completion pulse
    input wire logic [12:0] stack_top_in, // return address
    input wire logic stack_pop_out,       // pop pulse
    input wire logic [12:0] pc_out,       // program counter
    input wire logic [7:0] w_out,         // working register
    input wire logic [4:0] status_out,    // flags
    input wire logic halted_out,          // sleeping
    input wire logic osc_run_out,         // oscillator enable
    input wire logic wake_pin_in          // wake request
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    // an instruction of the given kind taken at this edge
    sequence s_take(logic [2:0] code);
        instr_valid_in && instr_ready_out && instr_op_in == code;
    endsequence
    // second half of the two-cycle return
    sequence s_ret_tail;
        !instr_done_out ##1 (instr_done_out && !instr_ready_out) ##1 instr_ready_out;
    endsequence

    a_ret_pop: assert property (s_take(rss_pkg::RSS_OP_RETURN_WITH_LITERAL) |-> stack_pop_out)
        else $error("return did not pop the stack");
    a_ret_load: assert property (s_take(rss_pkg::RSS_OP_RETURN_WITH_LITERAL) |=>
        w_out == $past(instr_imm_in) && pc_out == $past(stack_top_in))
        else $error("return did not load literal and pc");
    a_ret_two_cycles: assert property (s_take(rss_pkg::RSS_OP_RETURN_WITH_LITERAL) |-> s_ret_tail)
        else $error("return not two cycles");
    a_imm_sub_value: assert property (s_take(rss_pkg::RSS_OP_SUBTRACT_W_FROM_IMMEDIATE) |=>
        w_out == 8'($past(instr_imm_in) - $past(w_out)))
        else $error("literal minus w wrong");
    a_sub_carry_flags: assert property (s_take(rss_pkg::RSS_OP_SUBTRACT_W_FROM_IMMEDIATE) |=>
        status_out[0] == ($past(w_out) <= $past(instr_imm_in)) &&
        status_out[1] == ($past(w_out[3:0]) <= $past(instr_imm_in[3:0])))
        else $error("carry or digit carry wrong");
    a_sub_zero_flag: assert property (s_take(rss_pkg::RSS_OP_SUBTRACT_W_FROM_IMMEDIATE) |=>
        status_out[2] == (w_out == 8'h00))
        else $error("zero flag wrong");
    a_rot_carry_in: assert property (s_take(rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_CARRY) ##0 !instr_dest_in
        |-> ##2 w_out[7] == $past(status_out[0]))
        else $error("carry not rotated into bit 7");
    a_file_dest_keeps_w: assert property (instr_valid_in && instr_ready_out && instr_dest_in &&
        (instr_op_in inside {3'h2, 3'h3}) |-> ##2 w_out == $past(w_out, 2))
        else $error("file destination changed w");
    a_sleep_entry: assert property (s_take(rss_pkg::RSS_OP_SLEEP) |=>
        !status_out[3] && status_out[4] && halted_out && !osc_run_out)
        else $error("sleep entry flags or halt wrong");
    a_sleep_stays: assert property ((halted_out && !wake_pin_in)[*5] |=>
        halted_out && !osc_run_out && !instr_ready_out)
        else $error("left sleep without wake");
endmodule : rss_core_asserts

bind rss_core rss_core_asserts i_rss_core_asserts (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
    .instr_op_in(instr_op_in), .instr_dest_in(instr_dest_in), .instr_imm_in(instr_imm_in),
    .instr_ready_out(instr_ready_out), .instr_done_out(instr_done_out),
    .stack_top_in(stack_top_in), .stack_pop_out(stack_pop_out), .pc_out(pc_out),
    .w_out(w_out), .status_out(status_out), .halted_out(halted_out),
    .osc_run_out(osc_run_out), .wake_pin_in(wake_pin_in));
`default_nettype wire

// >>> rss_stack_model.sv
// partner: return address stack beside the core, one entry older per pop
`timescale 1ns/100ps
`default_nettype none
module rss_stack_model #(
    parameter logic [12:0] BASE = 13'h0123  // newest return address, arbitrary
) (
    input wire logic clk_in,     // core clock
    input wire logic rst_in,     // sync reset, high
    input wire logic pop_in,     // pop pulse from core
    output logic [12:0] top_out  // current stack top
);
    logic [3:0] depth;
    logic [3:0] next_depth;
    // each pop exposes a different address so a stale top shows up
    always_comb begin
        next_depth = pop_in ? depth + 4'h1 : depth;
    end
    always_ff @(posedge clk_in) begin
        depth <= rst_in ? 4'h0 : next_depth;
    end
    assign top_out = BASE + 13'(depth) * 13'h0011;
endmodule : rss_stack_model
`default_nettype wire

// >>> rss_core_tb_top.sv
// testbench: drives rss_core and checks register reads against a model
`timescale 1ns/100ps
`default_nettype none
module rss_core_tb_top;
    localparam logic [12:0] STACK_BASE = 13'h0123;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, valid = 1'b0, dest = 1'b0, wake = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, imm = 8'h00, w;
    logic [2:0] op = 3'h0;
    logic [6:0] file = 7'h00;
    logic [15:0] rdata;
    logic [12:0] top, pc;
    logic [4:0] st;
    logic ready, done, pop, halted, osc, pend = 1'b0;
    logic [7:0] ew = 8'h00;
    logic ec = 1'b0, edc = 1'b0, ez = 1'b0, epd = 1'b1, eto = 1'b1;
    logic [15:0] expq[$];
    int mismatches = 0, comparisons = 0, seed = 32'hE3A3B01C;

    rss_core i_rss_core (.core_clk_in(clk), .rst_in(rst), .bus_addr_in(addr),
        .bus_wdata_in(wdata), .bus_wr_in(wr), .bus_rd_in(rd), .bus_rdata_out(rdata),
        .instr_valid_in(valid), .instr_op_in(op), .instr_file_in(file), .instr_dest_in(dest),
        .instr_imm_in(imm), .instr_ready_out(ready), .instr_done_out(done),
        .stack_top_in(top), .stack_pop_out(pop), .pc_out(pc), .w_out(w), .status_out(st),
        .halted_out(halted), .osc_run_out(osc), .wake_pin_in(wake));
    rss_stack_model #(.BASE(STACK_BASE)) i_rss_stack_model (.clk_in(clk), .rst_in(rst),
        .pop_in(pop), .top_out(top));

    always #12.5 clk = ~clk;

    function automatic logic [15:0] stv();
        return {11'h000, eto, epd, ez, edc, ec};
    endfunction : stv
    task automatic close_out();
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    // strobes stay up between back-to-back transfers; this drops them
    task automatic bus_idle();
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus_idle
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        expq.push_back(e);
        @(posedge clk);
    endtask : rd_reg
    task automatic set_c(input logic c);
        ec = c;
        edc = 1'b0;
        ez = 1'b0;
        wr_reg(rss_pkg::RSS_REG_STATUS, {3'h0, eto, epd, 2'h0, c});
    endtask : set_c
    // bounded wait; running out counts as a mismatch
    task automatic wait_ready();
        int n;
        n = 0;
        #1;
        while (ready !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (ready !== 1'b1) begin
            mismatches++;
            $display("mismatch instr_ready_out expected 1 seen %b", ready);
        end
        @(posedge clk);
    endtask : wait_ready
    task automatic ex(input logic [2:0] o, input logic [6:0] f, input logic d, input logic [7:0] k);
        bus_idle();
        valid <= 1'b1;
        op <= o;
        file <= f;
        dest <= d;
        imm <= k;
        @(posedge clk);
        valid <= 1'b0;
        wait_ready();
    endtask : ex
    // minuend minus w with the expected flags
    task automatic sub_exp(input logic [7:0] m, output logic [7:0] r);
        r = m - ew;
        ec = ew <= m;
        edc = ew[3:0] <= m[3:0];
        ez = r == 8'h00;
    endtask : sub_exp
    task automatic chk_wst();
        rd_reg(rss_pkg::RSS_REG_W, {8'h00, ew});
        rd_reg(rss_pkg::RSS_REG_STATUS, stv());
    endtask : chk_wst

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        logic [15:0] e;
        if (pend) begin
            e = expq.pop_front();
            comparisons++;
            if (rdata !== e) begin
                mismatches++;
                $display("mismatch bus_rdata_out expected %h seen %h", e, rdata);
            end
        end
        pend <= rd;
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end

    initial begin
        int i, b;
        logic [7:0] k, v, r;
        logic [6:0] f;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_wst();
        rd_reg(rss_pkg::RSS_REG_PC, 16'h0000);
        rd_reg(8'h7E, 16'h0000);
        // literal minus w: equal, borrow by one, random
        for (i = 0; i < 10; i++) begin
            v = 8'($random(seed));
            k = (i == 0) ? v : (i == 1) ? v - 8'h01 : 8'($random(seed));
            wr_reg(rss_pkg::RSS_REG_W, v);
            ew = v;
            ex(rss_pkg::RSS_OP_SUBTRACT_W_FROM_IMMEDIATE, 7'h00, 1'b0, k);
            sub_exp(k, r);
            ew = r;
            chk_wst();
        end
        // file ops at both address ends; file loaded by rotating carry in
        for (i = 0; i < 4; i++) begin
            f = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($random(seed));
            v = 8'($random(seed));
            for (b = 0; b < 8; b++) begin
                set_c(v[b]);
                ex(rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_CARRY, f, 1'b1, 8'h00);
            end
            k = 8'($random(seed));
            set_c(k[0]);
            ex(rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_CARRY, f, 1'b0, 8'h00);
            ew = {k[0], v[7:1]};
            ec = v[0];
            chk_wst();
            wr_reg(rss_pkg::RSS_REG_W, k);
            ew = k;
            ex(rss_pkg::RSS_OP_SUBTRACT_W_FROM_FILE, f, 1'b1, 8'h00);
            sub_exp(v, v);
            chk_wst();
            ex(rss_pkg::RSS_OP_SUBTRACT_W_FROM_FILE, f, 1'b0, 8'h00);
            sub_exp(v, r);
            ew = r;
            chk_wst();
        end
        // two returns in turn, W and PC read after each, each popping a different address
        for (i = 0; i < 2; i++) begin
            k = 8'($random(seed));
            ex(rss_pkg::RSS_OP_RETURN_WITH_LITERAL, 7'h00, 1'b0, k);
            ew = k;
            rd_reg(rss_pkg::RSS_REG_W, {8'h00, ew});
            rd_reg(rss_pkg::RSS_REG_PC, {3'h0, STACK_BASE + 13'(i) * 13'h0011});
        end
        // watchdog runs past one prescaler wrap, then sleep clears it
        wr_reg(rss_pkg::RSS_REG_CTRL, 8'h01);
        rd_reg(rss_pkg::RSS_REG_CTRL, 16'h0001);
        bus_idle();
        repeat (10600) @(posedge clk);
        rd_reg(rss_pkg::RSS_REG_WDOG, 16'h0001);
        eto = 1'b0;
        wr_reg(rss_pkg::RSS_REG_STATUS, {3'h0, eto, epd, ez, edc, ec});
        rd_reg(rss_pkg::RSS_REG_STATUS, stv());
        bus_idle();
        valid <= 1'b1;
        op <= rss_pkg::RSS_OP_SLEEP;
        @(posedge clk);
        valid <= 1'b0;
        @(posedge clk);
        epd = 1'b0;
        eto = 1'b1;
        chk_wst();
        rd_reg(rss_pkg::RSS_REG_WDOG, 16'h0000);
        bus_idle();
        repeat (6) @(posedge clk);
        wake <= 1'b1;
        wait_ready();
        wake <= 1'b0;
        chk_wst();
        bus_idle();
        repeat (2) @(posedge clk);
        close_out();
    end
endmodule : rss_core_tb_top
`default_nettype wire
